// ---- logic/sbpu_bert.sv ----
/*
 * sbpu_bert: serial bit error rate tester between a serial tdm port and the line.
 * assumes one clock (serial port clock domain); gates and data come from logic on
 * the same clock; control bits are static plain ports driven by software-side logic.
 */
// Function
// RULE1: receive generator is 32-bit shift register, feedback enters bit 1 and is output
// RULE2: prbs feedback xors taps n and y; repetitive uses tap n; n,y programmable
// RULE3: qrss uses taps 17 and 20; output forced one after 14 zero bits
// RULE4: prbs and qrss force feedback one when taps 1..31 are zero
// RULE5: prbs sync loads 32 bits then needs 32 matching bits
// RULE6: six errors in 64-bit window start resync unless disabled
// RULE7: repetitive sync searches each bit position then checks 32 bits
// RULE8: unlocked whenever sync machine is outside sync state
// RULE9: mismatch counts error and bit; match counts bit only
// RULE10: no counting while unlocked
// RULE11: 24-bit error counter and 32-bit bit counter saturate
// RULE12: counters hold at maximum until snapshot clears them
// RULE13: snapshot edge drops done, copies, clears, pulses zero status, raises done
// RULE14: transmit generator follows same tap, qrss and zero-lock behaviour
// RULE15: new pattern preloads value for repetitive, all ones for prbs/qrss
// RULE16: repetitive length 1..32, value below two to the length
// RULE17: one bit error inserted per software request
// RULE18: inversion applies to pattern before overhead bits
// RULE19: enabling bert replaces normal traffic; disabling restores it
// RULE20: gates qualify bit times; no generate or check while gate low
// RULE21: unlock condition visible as software-readable status flag
`timescale 1ns/100ps
`default_nettype none

module sbpu_bert #(
	parameter int unsigned GEN_W = sbpu_pkg::GEN_W
) (
	// clock and reset
	input  wire logic                           clk_in,
	input  wire logic                           arst_n_in,
	// configuration
	input  wire logic                           bert_enable_in,
	input  wire logic                           repetitive_mode_in,
	input  wire logic                           qrss_enable_in,
	input  wire logic [sbpu_pkg::TAP_W-1:0]     tap_n_in,
	input  wire logic [sbpu_pkg::TAP_W-1:0]     tap_y_in,
	input  wire logic [GEN_W-1:0]               rep_value_in,
	input  wire logic                           load_pattern_in,
	input  wire logic                           resync_disable_in,
	input  wire logic                           invert_in,
	input  wire logic                           insert_error_in,
	// counter snapshot
	input  wire logic                           counter_snapshot_request_in,
	output logic                                counter_snapshot_done_out,
	output logic                                zero_count_n_out,
	output logic [sbpu_pkg::ERR_CNT_W-1:0]      err_count_out,
	output logic [sbpu_pkg::BIT_CNT_W-1:0]      bit_count_out,
	// status
	output logic                                pattern_unlocked_out,
	// normal traffic side
	input  wire logic                           sys_tx_data_in,
	output logic                                sys_rx_data_out,
	// line side
	input  wire logic                           rx_data_in,
	input  wire logic                           rx_bit_gate_in,
	input  wire logic                           tx_bit_gate_in,
	output logic                                tx_data_out
);

	// taps are numbered 1..GEN_W; bit k lives at index k-1
	function automatic logic tap_bit(input logic [GEN_W-1:0] g, input logic [sbpu_pkg::TAP_W-1:0] t);
		logic r;
		r = 1'b0;
		for (int i = 0; i < GEN_W; i++)
		begin
			if (t == sbpu_pkg::TAP_W'(i + 1))
				r = g[i];
		end
		return r;
	endfunction

	function automatic logic gen_fb(input logic [GEN_W-1:0] g, input logic rep, input logic qrss,
		input logic [sbpu_pkg::TAP_W-1:0] n, input logic [sbpu_pkg::TAP_W-1:0] y);
		logic f;
		if (rep)
			f = tap_bit(g, n); // [RULE2]
		else if (qrss)
			f = g[sbpu_pkg::QRSS_TAP_A-1] ^ g[sbpu_pkg::QRSS_TAP_B-1]; // [RULE3]
		else
			f = tap_bit(g, n) ^ tap_bit(g, y); // [RULE2]
		if (!rep && (g[sbpu_pkg::ZERO_LOCK_W-1:0] == '0))
			f = 1'b1; // [RULE4]
		return f;
	endfunction

	// output of the generator: feedback, or one after a long zero run in qrss
	function automatic logic gen_out(input logic [GEN_W-1:0] g, input logic rep, input logic qrss,
		input logic [sbpu_pkg::TAP_W-1:0] n, input logic [sbpu_pkg::TAP_W-1:0] y);
		logic o;
		o = gen_fb(g, rep, qrss, n, y); // [RULE1]
		if (!rep && qrss && (g[sbpu_pkg::QRSS_ZERO_RUN-1:0] == '0))
			o = 1'b1; // [RULE3]
		return o;
	endfunction

	// mask of the low n bits, used for the repetitive pattern compare
	function automatic logic [GEN_W-1:0] len_mask(input logic [sbpu_pkg::TAP_W-1:0] n);
		logic [GEN_W-1:0] m;
		m = '0;
		for (int i = 0; i < GEN_W; i++)
		begin
			if (sbpu_pkg::TAP_W'(i) < n)
				m[i] = 1'b1;
		end
		return m;
	endfunction

	logic                              rx_bit;
	logic                              tx_bit;
	logic [GEN_W-1:0]                  tx_gen_q;
	logic [GEN_W-1:0]                  rx_gen_q;
	logic [GEN_W-1:0]                  rx_hist_q;
	logic                              err_pend_q;
	logic                              ins_q;
	sbpu_pkg::sbpu_sync_e              sync_q;
	logic [sbpu_pkg::CNT7_W-1:0]       phase_cnt_q;
	logic [sbpu_pkg::CNT7_W-1:0]       win_cnt_q;
	logic [sbpu_pkg::CNT7_W-1:0]       win_err_q;
	logic [sbpu_pkg::ERR_CNT_W-1:0]    err_live_q;
	logic [sbpu_pkg::BIT_CNT_W-1:0]    bit_live_q;
	logic                              snap_req_q;
	logic [1:0]                        snap_st_q;
	logic                              rx_exp;
	logic                              rx_mis;
	logic                              rx_fb;
	logic                              rep_match;
	logic                              count_en;
	logic                              snap_edge;
	logic [GEN_W-1:0]                  rx_hist_nx;

	assign rx_bit     = rx_data_in;
	assign rx_exp     = gen_out(rx_gen_q, repetitive_mode_in, qrss_enable_in, tap_n_in, tap_y_in);
	assign rx_fb      = gen_fb(rx_gen_q, repetitive_mode_in, qrss_enable_in, tap_n_in, tap_y_in);
	assign rx_mis     = rx_bit ^ rx_exp; // [RULE9]
	assign rx_hist_nx = {rx_hist_q[GEN_W-2:0], rx_bit};
	assign rep_match  = ((rx_hist_nx ^ rep_value_in) & len_mask(tap_n_in)) == '0; // [RULE7]
	assign count_en   = bert_enable_in && rx_bit_gate_in && (sync_q == sbpu_pkg::SBPU_ST_SYNC); // [RULE10]
	assign snap_edge  = counter_snapshot_request_in && !snap_req_q;
	assign tx_bit     = gen_out(tx_gen_q, repetitive_mode_in, qrss_enable_in, tap_n_in, tap_y_in);

	// transmit generator; preload when a new pattern is loaded
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			tx_gen_q <= sbpu_pkg::SEED_ONES;
		else if (load_pattern_in)
			tx_gen_q <= repetitive_mode_in ? rep_value_in : sbpu_pkg::SEED_ONES; // [RULE15] [RULE16]
		else if (bert_enable_in && tx_bit_gate_in)
			tx_gen_q <= {tx_gen_q[GEN_W-2:0],
				gen_fb(tx_gen_q, repetitive_mode_in, qrss_enable_in, tap_n_in, tap_y_in)}; // [RULE14] [RULE20]
	end

	// error insertion: a request is held until the next gated transmit bit takes it
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			err_pend_q <= 1'b0;
			ins_q      <= 1'b0;
		end
		else
		begin
			ins_q <= insert_error_in;
			if (insert_error_in && !ins_q)
				err_pend_q <= 1'b1; // [RULE17]
			else if (bert_enable_in && tx_bit_gate_in)
				err_pend_q <= 1'b0;
		end
	end

	// line output and bert-versus-traffic steering
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			tx_data_out     <= 1'b0;
			sys_rx_data_out <= 1'b0;
		end
		else if (bert_enable_in)
		begin
			// traffic receive output is forced high while the bert owns the port
			sys_rx_data_out <= 1'b1; // [RULE19]
			if (tx_bit_gate_in)
				tx_data_out <= tx_bit ^ invert_in ^ err_pend_q; // [RULE18] [RULE17] [RULE20]
		end
		else
		begin
			tx_data_out     <= sys_tx_data_in; // [RULE19]
			sys_rx_data_out <= rx_bit;
		end
	end

	// receive generator and sync machine
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rx_gen_q    <= '0;
			rx_hist_q   <= '0;
			sync_q      <= sbpu_pkg::SBPU_ST_LOAD;
			phase_cnt_q <= '0;
			win_cnt_q   <= '0;
			win_err_q   <= '0;
		end
		else if (!bert_enable_in || load_pattern_in)
		begin
			sync_q      <= sbpu_pkg::SBPU_ST_LOAD;
			phase_cnt_q <= '0;
			win_cnt_q   <= '0;
			win_err_q   <= '0;
		end
		else if (rx_bit_gate_in) // [RULE20]
		begin
			rx_hist_q <= rx_hist_nx;
			unique case (sync_q)
				sbpu_pkg::SBPU_ST_LOAD:
				begin
					if (repetitive_mode_in)
					begin
						rx_gen_q <= rx_hist_nx;
						if (rep_match)
						begin
							sync_q      <= sbpu_pkg::SBPU_ST_CHECK; // [RULE7]
							phase_cnt_q <= '0;
						end
					end
					else
					begin
						rx_gen_q    <= rx_hist_nx; // [RULE5]
						phase_cnt_q <= phase_cnt_q + 1'b1;
						if (phase_cnt_q == sbpu_pkg::CNT7_W'(sbpu_pkg::CHECK_BITS - 1))
						begin
							sync_q      <= sbpu_pkg::SBPU_ST_CHECK;
							phase_cnt_q <= '0;
						end
					end
				end
				sbpu_pkg::SBPU_ST_CHECK:
				begin
					rx_gen_q    <= {rx_gen_q[GEN_W-2:0], rx_fb}; // [RULE1]
					phase_cnt_q <= phase_cnt_q + 1'b1;
					if (rx_mis)
					begin
						sync_q      <= sbpu_pkg::SBPU_ST_LOAD; // [RULE5] [RULE7]
						phase_cnt_q <= '0;
					end
					else if (phase_cnt_q == sbpu_pkg::CNT7_W'(sbpu_pkg::CHECK_BITS - 1))
					begin
						sync_q    <= sbpu_pkg::SBPU_ST_SYNC;
						win_cnt_q <= '0;
						win_err_q <= '0;
					end
				end
				sbpu_pkg::SBPU_ST_SYNC:
				begin
					rx_gen_q <= {rx_gen_q[GEN_W-2:0], rx_fb};
					if (!resync_disable_in && rx_mis &&
						(win_err_q >= sbpu_pkg::CNT7_W'(sbpu_pkg::RESYNC_ERRS - 1)))
					begin
						sync_q      <= sbpu_pkg::SBPU_ST_LOAD; // [RULE6]
						phase_cnt_q <= '0;
					end
					else if (win_cnt_q == sbpu_pkg::CNT7_W'(sbpu_pkg::WINDOW_BITS - 1))
					begin
						win_cnt_q <= '0;
						win_err_q <= '0;
					end
					else
					begin
						win_cnt_q <= win_cnt_q + 1'b1;
						if (rx_mis && (win_err_q != sbpu_pkg::CNT7_W'(sbpu_pkg::RESYNC_ERRS)))
							win_err_q <= win_err_q + 1'b1;
					end
				end
				default:
					sync_q <= sbpu_pkg::SBPU_ST_LOAD;
			endcase
		end
	end

	// unlock flag registered from the sync state, also set while the tester is off or a pattern loads
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pattern_unlocked_out <= 1'b1;
		else
			pattern_unlocked_out <= !bert_enable_in || load_pattern_in ||
				(sync_q != sbpu_pkg::SBPU_ST_SYNC); // [RULE8] [RULE21]
	end

	// live counters; on a snapshot edge the current bit restarts the count so none is lost
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			err_live_q <= '0;
			bit_live_q <= '0;
		end
		else if (snap_edge)
		begin
			err_live_q <= sbpu_pkg::ERR_CNT_W'(count_en && rx_mis); // [RULE13]
			bit_live_q <= sbpu_pkg::BIT_CNT_W'(count_en);
		end
		else if (count_en)
		begin
			if (bit_live_q != '1)
				bit_live_q <= bit_live_q + 1'b1; // [RULE9] [RULE11] [RULE12]
			if (rx_mis && (err_live_q != '1))
				err_live_q <= err_live_q + 1'b1; // [RULE9] [RULE11] [RULE12]
		end
	end

	// snapshot sequence: done low, copy, zero pulse, done high
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			snap_req_q                <= 1'b0;
			snap_st_q                 <= 2'b00;
			err_count_out             <= '0;
			bit_count_out             <= '0;
			counter_snapshot_done_out <= 1'b1;
			zero_count_n_out          <= 1'b1;
		end
		else
		begin
			snap_req_q <= counter_snapshot_request_in;
			if (snap_edge)
			begin
				counter_snapshot_done_out <= 1'b0; // [RULE13]
				err_count_out             <= err_live_q;
				bit_count_out             <= bit_live_q;
				snap_st_q                 <= 2'b01;
			end
			else if (snap_st_q == 2'b01)
			begin
				zero_count_n_out <= 1'b0; // [RULE13]
				snap_st_q        <= 2'b10;
			end
			else if (snap_st_q == 2'b10)
			begin
				zero_count_n_out          <= 1'b1;
				counter_snapshot_done_out <= 1'b1; // [RULE13]
				snap_st_q                 <= 2'b00;
			end
		end
	end

endmodule

`default_nettype wire

// ---- logic/sbpu_pkg.sv ----
/*
 * sbpu_pkg: constants shared by the serial bert pattern unit.
 * assumes nothing of its surroundings; pure definitions.
 */
package sbpu_pkg;

	localparam int unsigned GEN_W        = 32;
	localparam int unsigned ERR_CNT_W    = 24;
	localparam int unsigned BIT_CNT_W    = 32;
	localparam int unsigned TAP_W        = 6;
	localparam int unsigned QRSS_TAP_A   = 17;
	localparam int unsigned QRSS_TAP_B   = 20;
	localparam int unsigned QRSS_ZERO_RUN = 14;
	localparam int unsigned ZERO_LOCK_W  = 31;
	localparam int unsigned CHECK_BITS   = 32;
	localparam int unsigned WINDOW_BITS  = 64;
	localparam int unsigned RESYNC_ERRS  = 6;
	localparam int unsigned CNT7_W       = 7;

	localparam logic [GEN_W-1:0] SEED_ONES = 32'hFFFFFFFF;

	typedef enum logic [1:0]
	{
		SBPU_ST_LOAD  = 2'b00,
		SBPU_ST_CHECK = 2'b01,
		SBPU_ST_SYNC  = 2'b10
	} sbpu_sync_e;

endpackage

// ---- verif/sbpu_bert_monitor.sv ----
/* sbpu_bert_monitor: concurrent checks on the ports of sbpu_bert.
 * assumes a bind onto sbpu_bert and its single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module sbpu_bert_monitor (
	// clock, reset and control
	input wire logic		clk_in,
	input wire logic		arst_n_in,
	input wire logic		bert_enable_in,
	input wire logic		repetitive_mode_in,
	input wire logic		load_pattern_in,
	input wire logic		counter_snapshot_request_in,
	input wire logic		tx_bit_gate_in,
	input wire logic		rx_bit_gate_in,
	// observed outputs
	input wire logic		counter_snapshot_done_out,
	input wire logic		zero_count_n_out,
	input wire logic [sbpu_pkg::ERR_CNT_W-1:0]	err_count_out,
	input wire logic [sbpu_pkg::BIT_CNT_W-1:0]	bit_count_out,
	input wire logic		pattern_unlocked_out,
	input wire logic		sys_rx_data_out,
	input wire logic		tx_data_out
);
	logic		req_q;
	logic		rose_q;
	logic [6:0]	cnt_q;

	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	always_ff @(posedge clk_in or negedge arst_n_in)
		if (!arst_n_in)
			{req_q, rose_q} <= 2'h0;
		else
			{req_q, rose_q} <= {counter_snapshot_request_in, counter_snapshot_request_in & ~req_q};

	// gated rx bits seen since the last lock or load; undercounts by one after a resync, hence the margin
	always_ff @(posedge clk_in or negedge arst_n_in)
		if (!arst_n_in)
			cnt_q <= 7'h00;
		else if (load_pattern_in || !pattern_unlocked_out)
			cnt_q <= 7'h00;
		else if (bert_enable_in && rx_bit_gate_in && cnt_q != 7'h7F)
			cnt_q <= cnt_q + 7'h01;

	property p_snap_done;
		$rose(counter_snapshot_request_in) |=> !counter_snapshot_done_out[*2] ##1 counter_snapshot_done_out;
	endproperty
	a_snap_done: assert property (p_snap_done) else $error("snapshot done sequence wrong");
	property p_snap_zero;
		$rose(counter_snapshot_request_in) |-> ##2 !zero_count_n_out ##1 zero_count_n_out;
	endproperty
	a_snap_zero: assert property (p_snap_zero) else $error("zero count pulse wrong");
	property p_counts_stand;
		!rose_q |-> $stable(err_count_out) && $stable(bit_count_out);
	endproperty
	a_counts_stand: assert property (p_counts_stand) else $error("counts moved without snapshot");
	property p_err_le_bit;
		{8'h00, err_count_out} <= bit_count_out;
	endproperty
	a_err_le_bit: assert property (p_err_le_bit) else $error("error count above bit count");
	property p_unl_off;
		!bert_enable_in |=> pattern_unlocked_out;
	endproperty
	a_unl_off: assert property (p_unl_off) else $error("locked while tester off");
	property p_sys_rx_forced;
		bert_enable_in[*3] |-> sys_rx_data_out;
	endproperty
	a_sys_rx_forced: assert property (p_sys_rx_forced) else $error("traffic not blocked");
	property p_tx_hold;
		bert_enable_in[*2] ##0 (!tx_bit_gate_in && !load_pattern_in) |=> $stable(tx_data_out);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx bit moved while gated off");
	property p_lock_bits;
		$fell(pattern_unlocked_out) |-> cnt_q >= (repetitive_mode_in ? 7'h1F : 7'h3E);
	endproperty
	a_lock_bits: assert property (p_lock_bits) else $error("lock after too few bits");
endmodule
`default_nettype wire

// ---- verif/sbpu_line_model.sv ----
/* sbpu_line_model: far side of the serial port, looping line tx back into rx.
 * assumes the dut samples gates and data on the rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module sbpu_line_model (
	// clock and pacing
	input wire logic	clk_in,
	input wire logic	slow_in,
	// serial port pins
	input wire logic	tx_data_in,
	output var logic	tx_gate_out,
	output var logic	rx_gate_out,
	output var logic	rx_data_out
);
	logic	ph_q = 1'b0;

	initial
	begin
		{tx_gate_out, rx_gate_out, rx_data_out} = 3'h0;
	end

	// idle rx bits carry the inverse so a stale value can never pass as data
	always @(negedge clk_in)
	begin
		ph_q <= ~ph_q;
		tx_gate_out <= ~slow_in | ph_q;
		rx_gate_out <= tx_gate_out;
		rx_data_out <= tx_gate_out ? tx_data_in : ~rx_data_out;
	end
endmodule
`default_nettype wire

// ---- verif/sbpu_testbench.sv ----
/* testbench: self-checking run of sbpu_bert looped back through sbpu_line_model.
 * assumes package, design, monitor and line model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic		clk_in = 1'b0;
	logic		arst_n_in = 1'b0;
	logic		en, rep, qrss, load, rsd, inv, ins, req, sys_tx, slow;
	logic		done, zn, unl, sys_rx, rxd, rxg, txg, txd;
	logic [5:0]	tn, ty;
	logic [31:0]	rv, g, bc;
	logic [23:0]	ec;
	logic [63:0]	s;
	logic [37:0]	rcfg [3] = '{{6'h01, 32'h00000001}, {6'h08, 32'h000000A5}, {6'h20, 32'h0F0F00FF}};
	int		n_errors = 0;
	int		checks_done = 0;

	always #2 clk_in = ~clk_in;

	sbpu_bert dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .bert_enable_in(en), .repetitive_mode_in(rep),
		.qrss_enable_in(qrss), .tap_n_in(tn), .tap_y_in(ty), .rep_value_in(rv), .load_pattern_in(load),
		.resync_disable_in(rsd), .invert_in(inv), .insert_error_in(ins), .counter_snapshot_request_in(req),
		.counter_snapshot_done_out(done), .zero_count_n_out(zn), .err_count_out(ec), .bit_count_out(bc),
		.pattern_unlocked_out(unl), .sys_tx_data_in(sys_tx), .sys_rx_data_out(sys_rx), .rx_data_in(rxd),
		.rx_bit_gate_in(rxg), .tx_bit_gate_in(txg), .tx_data_out(txd));
	sbpu_line_model line_u (.clk_in(clk_in), .slow_in(slow), .tx_data_in(txd), .tx_gate_out(txg),
		.rx_gate_out(rxg), .rx_data_out(rxd));

	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		checks_done++;
		if (v !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_unl(input logic e, input int lim);
		int i;
		for (i = 0; i < lim && unl !== e; i++)
			tick(1);
		if (i >= lim)
		begin
			n_errors++;
			$display("ERROR lock_wait expected %h seen %h", e, unl);
			results();
		end
	endtask
	task automatic ld();
		load = 1'b1;
		tick(2);
		load = 1'b0;
	endtask
	task automatic snap();
		req = 1'b1;
		tick(1);
		chk("done_low", 0, done);
		tick(1);
		chk("zero_low", 0, zn);
		tick(1);
		chk("done_high", 2'h3, {zn, done});
		req = 1'b0;
		tick(1);
	endtask
	// counts of an interval of k cycles, timed from the previous snapshot request
	task automatic intv(input int k);
		tick(k - 4);
		snap();
	endtask

	initial
	begin
		{en, rep, qrss, load, rsd, inv, ins, req, sys_tx, slow} = '0;
		{tn, ty, rv} = {6'h03, 6'h03, 32'h0};
		tick(3);
		arst_n_in = 1'b1;
		chk("rst_flags", 3'h7, {done, zn, unl});
		chk("rst_counts", 0, {8'h00, ec} | bc);
		for (int v = 0; v < 2; v++)
		begin
			sys_tx = v[0];
			tick(4);
			chk("traffic", {2{v[0]}}, {txd, sys_rx});
		end
		en = 1'b1;
		tick(3);
		chk("bert_owns", 1, sys_rx);
		// n equal to y cancels the taps, so only the zero-lock guard keeps the stream alive
		for (int k = 0; k < 2; k++)
		begin
			ld();
			g = 32'hFFFFFFFF;
			repeat (40)
			begin
				tick(1);
				g = {g[30:0], (g[30:0] == 31'h0) | (g[tn-1] ^ g[ty-1])};
				chk("tx_prbs", g[0], txd);
			end
			{tn, ty} = {6'h09, 6'h05};
		end
		wait_unl(0, 200);
		chk("locked", 0, unl);
		snap();
		intv(100);
		chk("bits", 100, bc);
		chk("errs", 0, ec);
		ins = 1'b1;
		tick(2);
		ins = 1'b0;
		intv(97);
		chk("errs_ins", 1, ec);
		chk("kept_lock", 0, unl);
		slow <= 1'b1;
		tick(2);
		snap();
		intv(100);
		chk("bits_gapped", 50, bc);
		slow <= 1'b0;
		{rsd, inv} = 2'h3;
		tick(4);
		snap();
		intv(100);
		chk("errs_inv", 100, ec);
		chk("held", 0, unl);
		rsd = 1'b0;
		wait_unl(1, 4);
		chk("resync", 1, unl);
		snap();
		intv(100);
		chk("idle_counts", 0, {8'h00, ec} | bc);
		inv = 1'b0;
		qrss = 1'b1;
		ld();
		g = 32'hFFFFFFFF;
		repeat (40)
		begin
			tick(1);
			chk("tx_qrss", (g[16] ^ g[19]) | (g[13:0] == 14'h0), txd);
			g = {g[30:0], g[16] ^ g[19]};
		end
		wait_unl(0, 300);
		chk("qrss_lock", 0, unl);
		{qrss, rep} = 2'h1;
		for (int k = 0; k < 3; k++)
		begin
			{tn, rv} = rcfg[k];
			ld();
			wait_unl(0, 300);
			chk("rep_lock", 0, unl);
			for (int i = 0; i < 64; i++)
			begin
				tick(1);
				s = {txd, s[63:1]};
			end
			chk("rep_period", 0, |((s ^ (s >> tn)) & (64'hFFFFFFFFFFFFFFFF >> tn)));
			chk("rep_ones", $countones(rv), $countones(s[31:0] & (32'hFFFFFFFF >> (32 - tn))));
		end
		en = 1'b0;
		tick(3);
		chk("unlock_off", 1, unl);
		results();
	end
endmodule

bind sbpu_bert sbpu_bert_monitor mon_u (.*);
`default_nettype wire
